/* verilog/agdl_regs.vh */
`ifndef AGDL_REGS_VH
`define AGDL_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define AGDL_OFS_TON_MIN     4'h0
`define AGDL_OFS_TON_MAX     4'h4
`define AGDL_OFS_STATUS      4'h8
`define AGDL_OFS_DEMAG       4'hC

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AGDL_RST_TON_MIN     10'h019
`define AGDL_RST_TON_MAX     12'h3E8

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define AGDL_ST_LEVEL_LSB    0
`define AGDL_ST_ADAPT_BIT    5
`define AGDL_ST_LOWPWR_BIT   6
`define AGDL_ST_STATE_LSB    8

// ----------------------------------------------------------------------
// Level encoding
// ----------------------------------------------------------------------
`define AGDL_LEVEL_MIN       5'h01
`define AGDL_LEVEL_MAX       5'h10
`define AGDL_STREAK_LEN      6'h20
`define AGDL_DIS_CYCLES      3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AGDL_CLK_MHZ         50
`define AGDL_BASE_NS         300
`define AGDL_BASE_CYC        ((`AGDL_BASE_NS * `AGDL_CLK_MHZ + 999) / 1000)
`define AGDL_STOP_US         10
`define AGDL_STOP_CYC        (`AGDL_STOP_US * `AGDL_CLK_MHZ)

`endif

/* verilog/agdl_sync.v */
`timescale 1ns/1ns
module agdl_sync #(
  parameter W = 1
) (
  sys_clk,
  rst_n,
  async_in,
  sync_out
);
  input  wire         sys_clk;
  input  wire         rst_n;
  input  wire [W-1:0] async_in;
  output reg  [W-1:0] sync_out;

  reg [W-1:0] stage1_reg;

  // Multi-bit codes are treated as quasi-static; each bit is synced alone
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= {W{1'b0}};
      sync_out   <= {W{1'b0}};
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule // agdl_sync

/* verilog/agdl_demag_meter.v */
`timescale 1ns/1ns
`include "agdl_regs.vh"
module agdl_demag_meter (
  sys_clk,
  rst_n,
  sense_high,
  fall_pulse,
  end_pulse,
  demag_time,
  stop_pulse
);
  input  wire        sys_clk;
  input  wire        rst_n;
  input  wire        sense_high;
  output reg         fall_pulse;
  output reg         end_pulse;
  output reg  [11:0] demag_time;
  output reg         stop_pulse;

  localparam integer STOP_I    = `AGDL_STOP_CYC - 1;
  localparam [9:0]   STOP_LAST = STOP_I[9:0];

  reg        sense_d_reg;
  reg        timing_reg;
  reg [11:0] cnt_reg;
  reg [9:0]  stop_cnt_reg;

  // Time runs from the first fall below threshold to the first rise
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Same as the synchroniser's reset output, so no false fall
      sense_d_reg  <= 1'b0;
      timing_reg   <= 1'b0;
      cnt_reg      <= 12'h000;
      stop_cnt_reg <= 10'h000;
      fall_pulse   <= 1'b0;
      end_pulse    <= 1'b0;
      demag_time   <= 12'h000;
      stop_pulse   <= 1'b0;
    end else begin
      sense_d_reg <= sense_high;
      fall_pulse  <= sense_d_reg & ~sense_high;
      end_pulse   <= 1'b0;
      stop_pulse  <= 1'b0;
      if (sense_d_reg & ~sense_high) begin
        timing_reg <= 1'b1;
        cnt_reg    <= 12'h001;
      end else if (timing_reg & sense_high) begin
        timing_reg <= 1'b0;
        end_pulse  <= 1'b1;
        demag_time <= cnt_reg;
      end else if (timing_reg && cnt_reg != 12'hFFF) begin
        cnt_reg <= cnt_reg + 12'h001;
      end
      // Switching stop: sense held high with no falling edge
      if (!sense_high) begin
        stop_cnt_reg <= 10'h000;
      end else if (stop_cnt_reg != STOP_LAST) begin
        stop_cnt_reg <= stop_cnt_reg + 10'h001;
        stop_pulse   <= (stop_cnt_reg == STOP_LAST - 10'h001);
      end
    end
  end
endmodule // agdl_demag_meter

/* verilog/agdl_top.v */
`timescale 1ns/1ns
`include "agdl_regs.vh"
module agdl_top (
  sys_clk,
  rst_n,
  drain_sense_input,
  disable_input,
  supply_on_threshold,
  supply_adapt_enable_level,
  supply_adapt_disable_level,
  aux_supply_pin,
  supply_cap_code,
  supply_drop_code,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  gate_drive,
  gate_level,
  gate_hold_low
);
  input  wire        sys_clk;
  input  wire        rst_n;
  input  wire        drain_sense_input;
  input  wire        disable_input;
  input  wire        supply_on_threshold;
  input  wire        supply_adapt_enable_level;
  input  wire        supply_adapt_disable_level;
  input  wire        aux_supply_pin;
  input  wire [4:0]  supply_cap_code;
  input  wire [4:0]  supply_drop_code;
  input  wire [3:0]  reg_addr;
  input  wire [31:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [31:0] reg_rdata;
  output reg         gate_drive;
  output reg  [4:0]  gate_level;
  output reg         gate_hold_low;

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [3:0] ST_RUN   = 4'h1;
  localparam [3:0] ST_SLEEP = 4'h2;
  localparam [3:0] ST_BURST = 4'h4;
  localparam [3:0] ST_DIS   = 4'h8;
  localparam integer BASE_I   = `AGDL_BASE_CYC;
  localparam [15:0]  BASE_CYC = BASE_I[15:0];

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  wire [15:0] sync_bus;
  wire        s_sense;
  wire        s_dis;
  wire        s_on;
  wire        s_en;
  wire        s_dis_lvl;
  wire        s_aux;
  wire [4:0]  s_cap;
  wire [4:0]  s_drop;

  agdl_sync #(.W(16)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({supply_drop_code, supply_cap_code, aux_supply_pin,
                supply_adapt_disable_level, supply_adapt_enable_level,
                supply_on_threshold, disable_input, drain_sense_input}),
    .sync_out (sync_bus)
  );

  assign s_sense   = sync_bus[0];
  assign s_dis     = sync_bus[1];
  assign s_on      = sync_bus[2];
  assign s_en      = sync_bus[3];
  assign s_dis_lvl = sync_bus[4];
  assign s_aux     = sync_bus[5];
  assign s_cap     = sync_bus[10:6];
  assign s_drop    = sync_bus[15:11];

  wire        fall_p;
  wire        end_p;
  wire [11:0] td;
  wire        stop_p;

  agdl_demag_meter u_meter (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sense_high (s_sense),
    .fall_pulse (fall_p),
    .end_pulse  (end_p),
    .demag_time (td),
    .stop_pulse (stop_p)
  );

  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  reg [9:0]  ton_min_reg;
  reg [11:0] ton_max_reg;
  reg [11:0] last_td_reg;
  reg [3:0]  state_reg;
  reg        from_sleep_reg;
  reg [2:0]  dis_cnt_reg;
  reg [4:0]  level_reg;
  reg [5:0]  up_cnt_reg;
  reg [5:0]  dn_cnt_reg;
  reg        adapt_en_reg;
  reg [11:0] on_cnt_reg;

  // Largest band whose boundary the demag time reaches; compared at x6
  // to avoid a divider
  function [4:0] agdl_band;
    input [11:0] t;
    input [9:0]  tmin;
    reg   [15:0] lhs;
    reg   [15:0] rhs;
    reg   [15:0] tsub;
    reg   [4:0]  k;
    begin
      agdl_band = `AGDL_LEVEL_MIN;
      tsub = ({4'h0, t} > BASE_CYC) ? ({4'h0, t} - BASE_CYC) : 16'h0000;
      lhs = (tsub << 2) + (tsub << 1);
      for (k = 5'h01; k <= 5'h10; k = k + 5'h01) begin
        rhs = {6'h00, tmin} * ({11'h000, k} + 16'h0006);
        if (lhs >= rhs) begin
          agdl_band = k;
        end
      end
    end
  endfunction

  wire [4:0]  band = agdl_band(td, ton_min_reg);
  wire [15:0] td16 = {4'h0, td};
  wire [15:0] tmin16 = {6'h00, ton_min_reg};
  wire        sleep_in = (td16 <= tmin16 + BASE_CYC);
  wire [15:0] tsub5 = (td16 > BASE_CYC) ?
                      ((td16 - BASE_CYC) << 2) + (td16 - BASE_CYC) :
                      16'h0000;
  wire        sleep_out = (tsub5 > (tmin16 << 2) + (tmin16 << 1));

  // Adaptation off means the clamp index, still under the supply cap
  wire [4:0] eff_level = adapt_en_reg ? level_reg : `AGDL_LEVEL_MAX;
  wire [4:0] cap_level = s_aux ? s_cap : s_drop;
  wire [4:0] out_level = (eff_level < cap_level) ? eff_level : cap_level;

  wire gate_stop = s_sense | s_dis | ~s_on | (state_reg != ST_RUN) |
                   (on_cnt_reg >= ton_max_reg - 12'h001);

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ton_min_reg <= `AGDL_RST_TON_MIN;
      ton_max_reg <= `AGDL_RST_TON_MAX;
      reg_rdata   <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `AGDL_OFS_TON_MIN) begin
        ton_min_reg <= reg_wdata[9:0];
      end
      if (reg_wr && reg_addr == `AGDL_OFS_TON_MAX) begin
        ton_max_reg <= reg_wdata[11:0];
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `AGDL_OFS_TON_MIN: reg_rdata <= {22'h00_0000, ton_min_reg};
          `AGDL_OFS_TON_MAX: reg_rdata <= {20'h0_0000, ton_max_reg};
          `AGDL_OFS_STATUS: begin
            reg_rdata[`AGDL_ST_LEVEL_LSB +: 5]  <= level_reg;
            reg_rdata[`AGDL_ST_ADAPT_BIT]       <= adapt_en_reg;
            reg_rdata[`AGDL_ST_LOWPWR_BIT]      <=
              (dis_cnt_reg == `AGDL_DIS_CYCLES);
            reg_rdata[`AGDL_ST_STATE_LSB +: 4]  <= state_reg;
          end
          `AGDL_OFS_DEMAG: reg_rdata <= {20'h0_0000, last_td_reg};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode control and level adaptation
  // --------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_SLEEP;
      from_sleep_reg <= 1'b0;
      dis_cnt_reg    <= 3'h0;
      level_reg      <= `AGDL_LEVEL_MIN;
      up_cnt_reg     <= 6'h00;
      dn_cnt_reg     <= 6'h00;
      adapt_en_reg   <= 1'b0;
      last_td_reg    <= 12'h000;
    end else begin
      if (s_en) begin
        adapt_en_reg <= 1'b1;
      end else if (!s_dis_lvl) begin
        adapt_en_reg <= 1'b0;
      end
      if (end_p) begin
        last_td_reg <= td;
      end
      if (!s_on) begin
        state_reg   <= ST_SLEEP;
        level_reg   <= `AGDL_LEVEL_MIN;
        dis_cnt_reg <= 3'h0;
        up_cnt_reg  <= 6'h00;
        dn_cnt_reg  <= 6'h00;
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (s_dis) begin
              state_reg   <= ST_DIS;
              dis_cnt_reg <= 3'h0;
            end else if (stop_p) begin
              state_reg      <= ST_BURST;
              from_sleep_reg <= 1'b0;
            end else if (end_p && sleep_in) begin
              state_reg <= ST_SLEEP;
            end else if (end_p && adapt_en_reg) begin
              // Streaks restart on any cycle that leaves the band
              if (band > level_reg) begin
                dn_cnt_reg <= 6'h00;
                if (up_cnt_reg == `AGDL_STREAK_LEN - 6'h01) begin
                  up_cnt_reg <= 6'h00;
                  if (level_reg != `AGDL_LEVEL_MAX) begin
                    level_reg <= level_reg + 5'h01;
                  end
                end else begin
                  up_cnt_reg <= up_cnt_reg + 6'h01;
                end
              end else if (band < level_reg) begin
                up_cnt_reg <= 6'h00;
                if (dn_cnt_reg == `AGDL_STREAK_LEN - 6'h01) begin
                  dn_cnt_reg <= 6'h00;
                  if (level_reg != `AGDL_LEVEL_MIN) begin
                    level_reg <= level_reg - 5'h01;
                  end
                end else begin
                  dn_cnt_reg <= dn_cnt_reg + 6'h01;
                end
              end else begin
                up_cnt_reg <= 6'h00;
                dn_cnt_reg <= 6'h00;
              end
            end
          end
          ST_SLEEP: begin
            if (s_dis) begin
              state_reg   <= ST_DIS;
              dis_cnt_reg <= 3'h0;
            end else if (stop_p) begin
              state_reg      <= ST_BURST;
              from_sleep_reg <= 1'b1;
            end else if (end_p && sleep_out) begin
              state_reg   <= ST_RUN;
              level_reg   <= `AGDL_LEVEL_MIN;
              dis_cnt_reg <= 3'h0;
              up_cnt_reg  <= 6'h00;
              dn_cnt_reg  <= 6'h00;
            end
          end
          ST_BURST: begin
            // Resume on first fall; that cycle is not driven
            if (s_dis) begin
              state_reg   <= ST_DIS;
              dis_cnt_reg <= 3'h0;
            end else if (fall_p && from_sleep_reg) begin
              state_reg <= ST_SLEEP;
            end else if (fall_p) begin
              state_reg  <= ST_RUN;
              level_reg  <= `AGDL_LEVEL_MAX;
              up_cnt_reg <= 6'h00;
              dn_cnt_reg <= 6'h00;
            end
          end
          ST_DIS: begin
            if (!s_dis) begin
              // Low consumption exit needs a sleep-out cycle first
              state_reg <= (dis_cnt_reg == `AGDL_DIS_CYCLES) ?
                           ST_SLEEP : ST_RUN;
            end else if (fall_p && dis_cnt_reg != `AGDL_DIS_CYCLES) begin
              dis_cnt_reg <= dis_cnt_reg + 3'h1;
            end
          end
          default: begin
            state_reg <= ST_SLEEP;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Gate driver
  // --------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive    <= 1'b0;
      on_cnt_reg    <= 12'h000;
      gate_level    <= 5'h00;
      gate_hold_low <= 1'b1;
    end else begin
      gate_hold_low <= ~s_on;
      gate_level    <= out_level;
      if (gate_drive && gate_stop) begin
        gate_drive <= 1'b0;
      end else if (!gate_drive && fall_p && state_reg == ST_RUN &&
                   !s_dis && s_on) begin
        gate_drive <= 1'b1;
        on_cnt_reg <= 12'h000;
      end else if (gate_drive) begin
        on_cnt_reg <= on_cnt_reg + 12'h001;
      end
    end
  end
endmodule // agdl_top

/* tb/agdl_sense_model.sv */
`timescale 1ns/1ns
module agdl_sense_model (
  sys_clk,
  drain_sense_input
);
  input  wire sys_clk;
  output reg  drain_sense_input;
  // Drain idles high while the rectifier is off
  initial drain_sense_input = 1'b1;
  // One demagnetisation interval of td cycles, then gap cycles high
  task pulse(input int td, input int gap);
    @(posedge sys_clk);
    drain_sense_input <= 1'b0;
    repeat (td) @(posedge sys_clk);
    drain_sense_input <= 1'b1;
    repeat (gap) @(posedge sys_clk);
  endtask
endmodule // agdl_sense_model

/* tb/agdl_top_sva.sv */
`timescale 1ns/1ns
`include "agdl_regs.vh"
module agdl_top_sva (
  sys_clk,
  rst_n,
  drain_sense_input,
  disable_input,
  supply_on_threshold,
  supply_adapt_enable_level,
  supply_adapt_disable_level,
  aux_supply_pin,
  supply_cap_code,
  supply_drop_code,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  gate_drive,
  gate_level,
  gate_hold_low
);
  input wire        sys_clk;
  input wire        rst_n;
  input wire        drain_sense_input;
  input wire        disable_input;
  input wire        supply_on_threshold;
  input wire        supply_adapt_enable_level;
  input wire        supply_adapt_disable_level;
  input wire        aux_supply_pin;
  input wire [4:0]  supply_cap_code;
  input wire [4:0]  supply_drop_code;
  input wire [3:0]  reg_addr;
  input wire [31:0] reg_wdata;
  input wire        reg_wr;
  input wire        reg_rd;
  input wire [31:0] reg_rdata;
  input wire        gate_drive;
  input wire [4:0]  gate_level;
  input wire        gate_hold_low;
  reg  [11:0] ton_max_reg;
  reg  [11:0] on_cnt_reg;
  reg  [15:0] high_cnt_reg;
  wire [4:0]  cap_sel = aux_supply_pin ? supply_cap_code : supply_drop_code;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Limit shadow assumes the limit is not rewritten in mid-pulse
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ton_max_reg  <= `AGDL_RST_TON_MAX;
      on_cnt_reg   <= 12'h000;
      high_cnt_reg <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `AGDL_OFS_TON_MAX)
        ton_max_reg <= reg_wdata[11:0];
      on_cnt_reg <= gate_drive ? on_cnt_reg + 12'h001 : 12'h000;
      if (!drain_sense_input || disable_input || !supply_on_threshold)
        high_cnt_reg <= 16'h0000;
      else if (high_cnt_reg != 16'hFFFF)
        high_cnt_reg <= high_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_HOLD_LOW: assert property (
    !supply_on_threshold [*5] |-> gate_hold_low && !gate_drive)
    else $error("gate not held low at low supply");
  AST_DISABLE: assert property (
    disable_input [*5] |-> !gate_drive) else $error("gate driven while off");
  AST_SENSE_END: assert property (
    drain_sense_input [*5] |-> !gate_drive)
    else $error("gate on without conduction");
  AST_ON_TIME: assert property (
    on_cnt_reg <= ton_max_reg) else $error("pulse longer than limit");
  AST_LEVEL_RANGE: assert property (
    gate_drive |-> gate_level >= `AGDL_LEVEL_MIN &&
    gate_level <= `AGDL_LEVEL_MAX) else $error("level index out of range");
  AST_LEVEL_HOLD: assert property (
    gate_drive && $past(gate_drive) |-> $stable(gate_level))
    else $error("level moved inside a pulse");
  AST_CAP: assert property (
    $stable(cap_sel) [*5] |-> gate_level <= cap_sel)
    else $error("level above supply cap");
  AST_ADAPT_OFF: assert property (
    (!supply_adapt_enable_level && !supply_adapt_disable_level &&
    $stable(cap_sel)) [*5] |->
    gate_level == ((cap_sel < 5'h10) ? cap_sel : 5'h10))
    else $error("level not top with adaption off");
  AST_BURST: assert property (
    $past(reg_rd) && $past(reg_addr) == `AGDL_OFS_STATUS &&
    high_cnt_reg > 16'h0230 |-> reg_rdata[10])
    else $error("burst not flagged");
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  cover property (on_cnt_reg == ton_max_reg);
  cover property (gate_drive && gate_level == `AGDL_LEVEL_MAX);
  cover property ($past(reg_rd) && reg_rdata[10]);
endmodule // agdl_top_sva

/* tb/adaptive_gate_drive_level_control_bench.sv */
`timescale 1ns/1ns
`include "agdl_regs.vh"
module adaptive_gate_drive_level_control_bench;
  logic        sys_clk;
  logic        rst_n;
  wire         drain_sense_input;
  logic        disable_input;
  logic        supply_on_threshold;
  logic        supply_adapt_enable_level;
  logic        supply_adapt_disable_level;
  logic        aux_supply_pin;
  logic [4:0]  supply_cap_code;
  logic [4:0]  supply_drop_code;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [31:0] reg_rdata;
  wire         gate_drive;
  wire  [4:0]  gate_level;
  wire         gate_hold_low;
  logic [31:0] d;
  logic        a;
  logic [4:0]  c;
  logic [4:0]  p;
  int          failures;
  int          check_count;
  int          hi_cnt;
  int          hi_mark;
  int          cur_w;
  int          last_w;
  int          seed_v;
  localparam int TMIN = 6;
  localparam int TMAX = 30;
  localparam logic [3:0] S_RUN = 4'h1;
  localparam logic [3:0] S_SLP = 4'h2;
  localparam logic [3:0] S_BST = 4'h4;
  localparam logic [3:0] S_DIS = 4'h8;
  agdl_top uut (.*);
  agdl_sense_model sm (
    .sys_clk           (sys_clk),
    .drain_sense_input (drain_sense_input)
  );
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (gate_drive === 1'b1) begin
      cur_w <= cur_w + 1;
      hi_cnt <= hi_cnt + 1;
    end else if (cur_w != 0) begin
      last_w <= cur_w;
      cur_w <= 0;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] ad);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task st(input logic [3:0] s);
    rd(`AGDL_OFS_STATUS);
    check(d[11:8], s, "state");
  endtask
  function int band(int td);
    for (int n = 16; n >= 1; n--)
      if (6 * (td - 15) >= TMIN * (n + 6)) return n;
    return 1;
  endfunction
  // Each level move must be one step toward the band, 32 cycles apart
  task run(input int td, input int n, input logic [4:0] fin);
    logic [4:0] lv;
    int last;
    rd(`AGDL_OFS_STATUS);
    p = d[4:0];
    last = -1;
    for (int i = 0; i < n; i++) begin
      sm.pulse(td, 12);
      rd(`AGDL_OFS_STATUS);
      lv = d[4:0];
      if (lv != p) begin
        check(lv, (band(td) > p) ? p + 5'h01 : p - 5'h01, "step");
        if (last >= 0) check(i - last, 32, "streak");
        last = i;
        p = lv;
      end
    end
    check(p, fin, "final level");
    check(gate_level, fin, "gate level");
  endtask
  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1_600_000;
    failures++;
    complete_run();
  end
  initial begin
    {rst_n, disable_input, supply_on_threshold, aux_supply_pin} = 4'h0;
    {supply_adapt_enable_level, supply_adapt_disable_level} = 2'h0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 38'h0;
    supply_cap_code = 5'h1F;
    supply_drop_code = 5'h1F;
    {failures, check_count} = 0;
    seed_v = $urandom(24571);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    check(gate_hold_low, 1'b1, "hold low");
    rd(`AGDL_OFS_TON_MIN);
    check(d, `AGDL_RST_TON_MIN, "ton min reset");
    rd(`AGDL_OFS_TON_MAX);
    check(d, `AGDL_RST_TON_MAX, "ton max reset");
    rd(4'h2);
    check(d, 32'h0000_0000, "unmapped");
    wr(`AGDL_OFS_TON_MIN, TMIN);
    wr(`AGDL_OFS_TON_MAX, TMAX);
    rd(`AGDL_OFS_TON_MAX);
    check(d, TMAX, "ton max");
    supply_on_threshold <= 1'b1;
    {supply_adapt_enable_level, supply_adapt_disable_level} <= 2'h3;
    repeat (5) @(posedge sys_clk);
    check(gate_hold_low, 1'b0, "hold low off");
    st(S_SLP);
    sm.pulse(23, 12);
    st(S_RUN);
    check(d[4:0], `AGDL_LEVEL_MIN, "start level");
    sm.pulse(40, 12);
    check(last_w >= TMAX - 1 && last_w <= TMAX, 1'b1, "pulse width");
    rd(`AGDL_OFS_DEMAG);
    check(d, 40, "demag time");
    run(40, 520, 5'h10);
    run(30, 240, band(30));
    for (int k = 0; k < 4; k++) begin
      a = 1'($urandom % 2);
      c = 5'(1 + $urandom % 31);
      p = 5'(1 + $urandom % 31);
      aux_supply_pin <= a;
      supply_cap_code <= c;
      supply_drop_code <= p;
      repeat (6) @(posedge sys_clk);
      p = a ? c : p;
      check(gate_level, (p < 9) ? p : 5'h09, "capped level");
    end
    {supply_cap_code, supply_drop_code} <= 10'h3FF;
    {supply_adapt_enable_level, supply_adapt_disable_level} <= 2'h0;
    repeat (6) @(posedge sys_clk);
    check(gate_level, 5'h10, "adapt off level");
    for (int k = 1; k < 4; k++) begin
      {supply_adapt_enable_level, supply_adapt_disable_level} <= k[1:0];
      repeat (6) @(posedge sys_clk);
      rd(`AGDL_OFS_STATUS);
      check(d[5], k > 1, "adapt enable");
    end
    {supply_adapt_enable_level, supply_adapt_disable_level} <= 2'h1;
    repeat (6) @(posedge sys_clk);
    rd(`AGDL_OFS_STATUS);
    check(d[5], 1'b1, "adapt hold");
    sm.pulse(22, 12);
    st(S_RUN);
    sm.pulse(21, 12);
    st(S_SLP);
    sm.pulse(22, 12);
    st(S_SLP);
    sm.pulse(23, 12);
    st(S_RUN);
    check(d[4:0], `AGDL_LEVEL_MIN, "sleep exit level");
    repeat (600) @(posedge sys_clk);
    st(S_BST);
    hi_mark = hi_cnt;
    sm.pulse(40, 12);
    check(hi_cnt - hi_mark, 0, "skipped first");
    st(S_RUN);
    check(d[4:0], `AGDL_LEVEL_MAX, "burst exit level");
    disable_input <= 1'b1;
    hi_mark = hi_cnt;
    for (int k = 1; k <= 4; k++) begin
      sm.pulse(40, 12);
      rd(`AGDL_OFS_STATUS);
      check(d[6], k == 4, "low power");
    end
    check(d[11:8], S_DIS, "disabled state");
    check(hi_cnt - hi_mark, 0, "no drive disabled");
    disable_input <= 1'b0;
    repeat (5) @(posedge sys_clk);
    st(S_SLP);
    sm.pulse(40, 12);
    st(S_RUN);
    check(d[4:0], `AGDL_LEVEL_MIN, "enable exit level");
    // Burst entered from sleep goes back to sleep on the first fall
    sm.pulse(21, 12);
    st(S_SLP);
    repeat (600) @(posedge sys_clk);
    st(S_BST);
    sm.pulse(22, 12);
    st(S_SLP);
    supply_on_threshold <= 1'b0;
    repeat (5) @(posedge sys_clk);
    hi_mark = hi_cnt;
    sm.pulse(40, 12);
    check(gate_hold_low, 1'b1, "hold low again");
    check(hi_cnt - hi_mark, 0, "no drive low supply");
    complete_run();
  end
endmodule // adaptive_gate_drive_level_control_bench
bind agdl_top agdl_top_sva chk (.*);
